//--- tgcr_consts.svh
`ifndef TGCR_CONSTS_SVH
`define TGCR_CONSTS_SVH
// Register offsets (word index; byte address is index times four)
`define TGCR_IDX_REV      8'h00
`define TGCR_IDX_IDL      8'h01
`define TGCR_IDX_IDH      8'h02
`define TGCR_IDX_SCRATCH  8'h03
`define TGCR_IDX_KEYH     8'h04
`define TGCR_IDX_KEYL     8'h05
`define TGCR_IDX_SRST     8'h06
`define TGCR_IDX_CTRL     8'h08
`define TGCR_IDX_MUXSEL   8'h09
// Protected window bounds
`define TGCR_LOCK_LO      8'h06
`define TGCR_LOCK_HI      8'h7f
// Control field positions
`define TGCR_CTRL_LPBK    0
`define TGCR_CTRL_PSRC    3
`define TGCR_CTRL_OHEN    4
`define TGCR_SRST_BIT     0
// Reset values
`define TGCR_RST_BYTE     8'h00
`define TGCR_RST_MUX      8'hff
`define TGCR_RST_RDATA    32'h0000_0000
`define TGCR_ADDR_LSB     2
`endif

//--- tgcr_pkg.sv
package tgcr_pkg;
    // Bus access phase
    typedef enum logic [1:0] {
        TGCR_IDLE,
        TGCR_ACK
    } tgcr_phase_t;
    typedef logic [7:0] tgcr_byte_t;
endpackage

//--- tgcr_regs.sv
// Summary of operation
// R1: Scratch byte read/write, no other effect
// R2: Writes 06..7F ignored unless key matches
// R3: Any reset returns the block to locked
// R4: Scratch writable regardless of lock state
// R5: Bit0 at 06 fires soft global reset
// R6: Loopback bit routes tx serial to rx
// R7: Source bit clear: muxes follow register 09
// R8: Source bit set: muxes follow pins
// R9: Overhead bit zero tri-states overhead outputs
// R10: Reset command pulses once, reads zero
`timescale 1ns/100ps
`include "tgcr_consts.svh"
module tgcr_regs
    import tgcr_pkg::*;
#(
    parameter tgcr_byte_t REV_CODE = 8'h3c,  // Arbitrary value
    parameter tgcr_byte_t ID_LOW   = 8'h5a,  // Arbitrary value
    parameter tgcr_byte_t ID_HIGH  = 8'h17   // Arbitrary value
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [9:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [3:0]  byteenable,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    output logic             global_reset,
    input  wire logic        tx_serial,
    input  wire logic        rx_serial_pin,
    output logic             rx_serial,
    input  wire logic [7:0]  prot_switch_pins,
    output logic      [7:0]  prot_mux_select,
    input  wire logic        rx_overhead_clock_enable_int,
    input  wire logic        rx_overhead_frame_pulse_int,
    output logic             rx_overhead_clock_enable_out,
    output logic             rx_overhead_frame_pulse_out,
    output logic             overhead_output_drive_enable
);
    // Register state
    tgcr_phase_t  phase, next_phase;          // Bus handshake phase
    tgcr_byte_t   scratch, next_scratch;      // Scratch byte
    tgcr_byte_t   key_high, next_key_high;    // Unlock key upper byte
    tgcr_byte_t   key_low, next_key_low;      // Unlock key lower byte
    tgcr_byte_t   ctrl, next_ctrl;            // Device control
    tgcr_byte_t   mux_reg, next_mux_reg;      // Software mux selects
    logic [31:0]  next_readdata;              // Read data to register
    logic         soft_rst, next_soft_rst;    // Soft reset pulse
    logic [7:0]   idx;                        // Word index
    logic         unlocked;                   // Key matches
    logic         wr_take;                    // Write accepted this edge
    logic         rd_take;                    // Read request seen, answer next cycle
    logic         lane0;                      // Low byte enabled
    logic         in_lock;                    // Address in protected window
    logic         core_rst;                   // Pin or soft reset
    // Pin synchronisers (three stages)
    logic [2:0]   rxs_sync;                   // Rx serial pin stages
    logic [7:0]   psw_s1, psw_s2, psw_s3;     // Protection pin stages
    logic [7:0]   psw_stable, next_psw_stable;// Filtered protection pins
    logic         rx_stable, next_rx_stable;  // Filtered rx serial
    // Output registers
    logic         next_rx_serial;
    tgcr_byte_t   next_mux_sel;
    logic         next_ohck, next_ohfp, next_ohen;

    assign idx      = address[`TGCR_ADDR_LSB +: 8];
    assign lane0    = byteenable[0];
    assign wr_take  = (phase == TGCR_ACK) && write;
    assign rd_take  = (phase == TGCR_IDLE) && read;  // Load data for the answer cycle
    assign unlocked = (key_high == REV_CODE) && (key_low == ID_LOW);
    assign in_lock  = (idx >= `TGCR_LOCK_LO) && (idx <= `TGCR_LOCK_HI);
    assign core_rst = srst || soft_rst;  // R5

    // Handshake: one wait cycle then answer
    always_comb begin
        next_phase = TGCR_IDLE;
        if (phase == TGCR_IDLE && (read || write)) begin
            next_phase = TGCR_ACK;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            phase <= TGCR_IDLE;
        end else begin
            phase <= next_phase;
        end
    end

    // Register writes
    always_comb begin
        next_scratch  = scratch;
        next_key_high = key_high;
        next_key_low  = key_low;
        next_ctrl     = ctrl;
        next_mux_reg  = mux_reg;
        next_soft_rst = 1'b0;  // R10
        if (wr_take && lane0) begin
            unique case (idx)
                `TGCR_IDX_SCRATCH: begin
                    next_scratch = writedata[7:0];  // R1 R4
                end
                `TGCR_IDX_KEYH: begin
                    next_key_high = writedata[7:0];
                end
                `TGCR_IDX_KEYL: begin
                    next_key_low = writedata[7:0];
                end
                default: begin
                    // Protected window needs the key
                    if (in_lock && unlocked) begin  // R2
                        if (idx == `TGCR_IDX_SRST) begin
                            next_soft_rst = writedata[`TGCR_SRST_BIT];  // R5
                        end
                        if (idx == `TGCR_IDX_CTRL) begin
                            next_ctrl = writedata[7:0];
                        end
                        if (idx == `TGCR_IDX_MUXSEL) begin
                            next_mux_reg = writedata[7:0];
                        end
                    end
                end
            endcase
        end
    end

    // Pin or soft reset clears scratch, keys and ctrl and sets mux_reg to ff, relocking the block
    always_ff @(posedge clk) begin
        if (core_rst) begin  // R3 R5
            scratch  <= `TGCR_RST_BYTE;
            key_high <= `TGCR_RST_BYTE;
            key_low  <= `TGCR_RST_BYTE;
            ctrl     <= `TGCR_RST_BYTE;
            mux_reg  <= `TGCR_RST_MUX;
            soft_rst <= 1'b0;
        end else begin
            scratch  <= next_scratch;
            key_high <= next_key_high;
            key_low  <= next_key_low;
            ctrl     <= next_ctrl;
            mux_reg  <= next_mux_reg;
            soft_rst <= next_soft_rst;
        end
    end

    // Read mux; pulse register reads zero
    // Loaded when the request is first seen, so data stands while waitrequest is low
    always_comb begin
        next_readdata = `TGCR_RST_RDATA;
        if (rd_take) begin
            unique case (idx)
                `TGCR_IDX_REV:     next_readdata[7:0] = REV_CODE;
                `TGCR_IDX_IDL:     next_readdata[7:0] = ID_LOW;
                `TGCR_IDX_IDH:     next_readdata[7:0] = ID_HIGH;
                `TGCR_IDX_SCRATCH: next_readdata[7:0] = scratch;  // R1
                `TGCR_IDX_KEYH:    next_readdata[7:0] = key_high;
                `TGCR_IDX_KEYL:    next_readdata[7:0] = key_low;
                `TGCR_IDX_CTRL:    next_readdata[7:0] = ctrl;
                `TGCR_IDX_MUXSEL:  next_readdata[7:0] = mux_reg;
                default:           next_readdata = `TGCR_RST_RDATA;  // R10
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            readdata <= `TGCR_RST_RDATA;
        end else begin
            readdata <= next_readdata;
        end
    end

    // Waitrequest high except in the answer cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= !(next_phase == TGCR_ACK);
        end
    end

    // Pin synchronisers: change counts once stages two and three agree
    always_ff @(posedge clk) begin
        rxs_sync <= {rxs_sync[1:0], rx_serial_pin};
        psw_s1   <= prot_switch_pins;
        psw_s2   <= psw_s1;
        psw_s3   <= psw_s2;
    end

    always_comb begin
        next_rx_stable = rx_stable;
        if (rxs_sync[1] == rxs_sync[2]) begin
            next_rx_stable = rxs_sync[2];
        end
    end

    // Per-bit filter on protection pins
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_psw
            always_comb begin
                next_psw_stable[gi] = psw_stable[gi];
                if (psw_s2[gi] == psw_s3[gi]) begin
                    next_psw_stable[gi] = psw_s3[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (srst) begin
            rx_stable  <= 1'b0;
            psw_stable <= `TGCR_RST_BYTE;
        end else begin
            rx_stable  <= next_rx_stable;
            psw_stable <= next_psw_stable;
        end
    end

    // Datapath selects driven from control register
    always_comb begin
        next_rx_serial = ctrl[`TGCR_CTRL_LPBK] ? tx_serial : rx_stable;                  // R6
        next_mux_sel   = ctrl[`TGCR_CTRL_PSRC] ? psw_stable : mux_reg;                   // R7 R8
        next_ohen      = ctrl[`TGCR_CTRL_OHEN];                                          // R9
        next_ohck      = ctrl[`TGCR_CTRL_OHEN] ? rx_overhead_clock_enable_int : 1'b0;    // R9
        next_ohfp      = ctrl[`TGCR_CTRL_OHEN] ? rx_overhead_frame_pulse_int : 1'b0;     // R9
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rx_serial                    <= 1'b0;
            prot_mux_select              <= `TGCR_RST_MUX;
            overhead_output_drive_enable <= 1'b0;
            rx_overhead_clock_enable_out <= 1'b0;
            rx_overhead_frame_pulse_out  <= 1'b0;
            global_reset                 <= 1'b0;
        end else begin
            rx_serial                    <= next_rx_serial;
            prot_mux_select              <= next_mux_sel;
            overhead_output_drive_enable <= next_ohen;
            rx_overhead_clock_enable_out <= next_ohck;
            rx_overhead_frame_pulse_out  <= next_ohfp;
            global_reset                 <= soft_rst;
        end
    end

    // Checks
    sequence s_key_write;
        wr_take && lane0 && idx == `TGCR_IDX_CTRL && !unlocked;
    endsequence

    locked_ctrl_a: assert property (@(posedge clk) disable iff (core_rst)  // R2
        s_key_write |=> $stable(ctrl))
        else $error("Locked control write took effect");
    scratch_write_a: assert property (@(posedge clk) disable iff (core_rst)  // R4
        wr_take && lane0 && idx == `TGCR_IDX_SCRATCH |=> scratch == $past(writedata[7:0]))
        else $error("Scratch write lost");
    relock_a: assert property (@(posedge clk)  // R3
        soft_rst |=> key_high == `TGCR_RST_BYTE && key_low == `TGCR_RST_BYTE)
        else $error("Block not locked after soft reset");
    pulse_once_a: assert property (@(posedge clk) disable iff (srst)  // R10
        soft_rst |=> !soft_rst)
        else $error("Reset command held");
    soft_rst_out_a: assert property (@(posedge clk) disable iff (srst)  // R5
        soft_rst |=> global_reset)
        else $error("Global reset not issued");
    loopback_a: assert property (@(posedge clk) disable iff (srst)  // R6
        ctrl[`TGCR_CTRL_LPBK] |=> rx_serial == $past(tx_serial))
        else $error("Loopback not routed");
    sw_mux_a: assert property (@(posedge clk) disable iff (srst)  // R7
        !ctrl[`TGCR_CTRL_PSRC] |=> prot_mux_select == $past(mux_reg))
        else $error("Mux not following register");
    pin_mux_a: assert property (@(posedge clk) disable iff (srst)  // R8
        ctrl[`TGCR_CTRL_PSRC] |=> prot_mux_select == $past(psw_stable))
        else $error("Mux not following pins");
    overhead_hiz_a: assert property (@(posedge clk) disable iff (srst)  // R9
        !ctrl[`TGCR_CTRL_OHEN] |=> !overhead_output_drive_enable && !rx_overhead_frame_pulse_out
            && !rx_overhead_clock_enable_out)
        else $error("Overhead outputs driven while disabled");
    // Soft reset clears both scratch and control at once, so skip that edge
    scratch_iso_a: assert property (@(posedge clk) disable iff (core_rst)  // R1
        $changed(scratch) && !$past(core_rst) |-> $stable(ctrl) && $stable(mux_reg))
        else $error("Scratch write disturbed control");

    // Unlocked control write lands
    sequence s_open_ctrl_write;
        wr_take && lane0 && idx == `TGCR_IDX_CTRL && unlocked;
    endsequence

    open_ctrl_a: assert property (@(posedge clk) disable iff (core_rst)  // R2
        s_open_ctrl_write |=> ctrl == $past(writedata[7:0]))
        else $error("Unlocked control write lost");
    // Soft reset clears the writable registers
    soft_clear_a: assert property (@(posedge clk)  // R5
        soft_rst |=> scratch == `TGCR_RST_BYTE && ctrl == `TGCR_RST_BYTE && mux_reg == `TGCR_RST_MUX)
        else $error("Soft reset left register state");
    // Pulse register reads back inactive
    pulse_read_a: assert property (@(posedge clk) disable iff (srst)  // R10
        rd_take && idx == `TGCR_IDX_SRST |=> readdata == `TGCR_RST_RDATA)
        else $error("Pulse register read nonzero");
    // Answer comes one cycle after a request
    one_wait_a: assert property (@(posedge clk) disable iff (srst)
        phase == TGCR_IDLE && (read || write) |=> !waitrequest)
        else $error("Bus answer late");
endmodule

//--- transceiver_global_control_regs_tb_top.sv
`timescale 1ns/100ps
`include "tgcr_consts.svh"
module transceiver_global_control_regs_tb_top
    import tgcr_pkg::*;
;
    localparam tgcr_byte_t REV = 8'h3c;  // Arbitrary value
    localparam tgcr_byte_t IDL = 8'h5a;  // Arbitrary value
    localparam tgcr_byte_t IDH = 8'h17;  // Arbitrary value
    // Design stimulus and observed pins
    logic        clk, srst, read, write, tx_serial, rx_serial_pin, ce_int, fp_int;
    logic [9:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata, readdata;
    logic [7:0]  pins, prot_mux_select;
    logic        waitrequest, global_reset, rx_serial, ce_out, fp_out, oh_en;
    // Bench bookkeeping
    int          n_fail, samples_checked, pulses;
    tgcr_byte_t  exp_q[$];
    tgcr_byte_t  r;

    tgcr_regs #(.REV_CODE(REV), .ID_LOW(IDL), .ID_HIGH(IDH)) uut (
        .clk(clk), .srst(srst), .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .global_reset(global_reset), .tx_serial(tx_serial),
        .rx_serial_pin(rx_serial_pin), .rx_serial(rx_serial), .prot_switch_pins(pins),
        .prot_mux_select(prot_mux_select), .rx_overhead_clock_enable_int(ce_int),
        .rx_overhead_frame_pulse_int(fp_int), .rx_overhead_clock_enable_out(ce_out),
        .rx_overhead_frame_pulse_out(fp_out), .overhead_output_drive_enable(oh_en));

    // Free running clock
    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    // Compare one value and count it
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask

    // Verdict and end of run
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // One bus cycle, held until waitrequest is sampled low
    task automatic bus(input bit w, input tgcr_byte_t idx, input tgcr_byte_t d);
        @(posedge clk);
        address   <= {idx, 2'b00};
        read      <= !w;
        write     <= w;
        writedata <= {24'h00_0000, d};
        // Only the watchdog ends a hung wait
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        read  <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input tgcr_byte_t idx, input tgcr_byte_t d);
        bus(1'b1, idx, d);
    endtask

    // Read: note the expectation, the monitor compares it
    task automatic rd(input tgcr_byte_t idx, input tgcr_byte_t e);
        exp_q.push_back(e);
        bus(1'b0, idx, 8'h00);
    endtask

    // Read data monitor takes the oldest expectation
    always @(posedge clk) begin
        if (read === 1'b1 && waitrequest === 1'b0 && exp_q.size() > 0)
            chk("readdata", {24'h00_0000, exp_q.pop_front()}, readdata);
    end

    // Soft reset pulse counter
    always @(posedge clk) begin
        if (global_reset === 1'b1)
            pulses++;
    end

    // Watchdog against a hung handshake
    initial begin
        #(25 * 5000);
        n_fail++;
        conclude();
    end

    // Main sequence
    initial begin
        {srst, read, write, tx_serial, rx_serial_pin, ce_int, fp_int} = 7'b100_0000;
        address = 10'h000;
        byteenable = 4'hf;
        writedata = 32'h0000_0000;
        pins = 8'h00;
        void'($urandom(32'hce7e));
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        rd(`TGCR_IDX_REV, REV);
        rd(`TGCR_IDX_IDL, IDL);
        rd(`TGCR_IDX_IDH, IDH);
        wr(`TGCR_IDX_REV, 8'hff);
        rd(`TGCR_IDX_REV, REV);
        r = 8'($urandom);
        wr(`TGCR_IDX_SCRATCH, r);
        rd(`TGCR_IDX_SCRATCH, r);
        byteenable <= 4'he;
        wr(`TGCR_IDX_SCRATCH, ~r);
        byteenable <= 4'hf;
        rd(`TGCR_IDX_SCRATCH, r);
        wr(`TGCR_IDX_CTRL, 8'h19);
        rd(`TGCR_IDX_CTRL, 8'h00);
        rd(8'h40, 8'h00);
        wr(`TGCR_IDX_KEYH, REV);
        wr(`TGCR_IDX_KEYL, IDH);
        wr(`TGCR_IDX_CTRL, 8'h19);
        rd(`TGCR_IDX_CTRL, 8'h00);
        wr(`TGCR_IDX_KEYL, IDL);
        rd(`TGCR_IDX_KEYH, REV);
        rd(`TGCR_IDX_KEYL, IDL);
        r = 8'($urandom);
        wr(`TGCR_IDX_MUXSEL, r);
        repeat (3) @(posedge clk);
        chk("prot_mux_select", r, prot_mux_select);
        wr(`TGCR_IDX_CTRL, 8'h08);
        for (int i = 0; i < 2; i++) begin
            pins <= 8'($urandom);
            repeat (7) @(posedge clk);
            chk("prot_mux_select", pins, prot_mux_select);
        end
        wr(`TGCR_IDX_CTRL, 8'h01);
        for (int i = 0; i < 2; i++) begin
            tx_serial     <= i[0];
            rx_serial_pin <= !i[0];
            repeat (4) @(posedge clk);
            chk("rx_serial", i[0], rx_serial);
        end
        wr(`TGCR_IDX_CTRL, 8'h00);
        ce_int <= 1'b1;
        fp_int <= 1'b1;
        repeat (7) @(posedge clk);
        chk("rx_serial", 1'b0, rx_serial);
        chk("overhead_drive", 1'b0, oh_en);
        chk("overhead_outs", 2'b00, {ce_out, fp_out});
        wr(`TGCR_IDX_CTRL, 8'h10);
        for (int i = 1; i < 4; i++) begin
            {ce_int, fp_int} <= i[1:0];
            repeat (3) @(posedge clk);
            chk("overhead_drive", 1'b1, oh_en);
            chk("overhead_outs", i[1:0], {ce_out, fp_out});
        end
        rd(`TGCR_IDX_CTRL, 8'h10);
        wr(`TGCR_IDX_SCRATCH, 8'ha5);
        pulses = 0;
        wr(`TGCR_IDX_SRST, 8'h01);
        repeat (4) @(posedge clk);
        chk("global_reset_pulses", 1, pulses);
        rd(`TGCR_IDX_SRST, 8'h00);
        rd(`TGCR_IDX_CTRL, 8'h00);
        rd(`TGCR_IDX_SCRATCH, 8'h00);
        rd(`TGCR_IDX_KEYH, 8'h00);
        chk("prot_mux_select", 8'hff, prot_mux_select);
        chk("overhead_drive", 1'b0, oh_en);
        wr(`TGCR_IDX_CTRL, 8'h10);
        rd(`TGCR_IDX_CTRL, 8'h00);
        wr(`TGCR_IDX_SCRATCH, 8'h3e);
        rd(`TGCR_IDX_SCRATCH, 8'h3e);
        repeat (2) @(posedge clk);
        conclude();
    end
endmodule
